// >>> dv/regulator_event_status_mask_tb_top.sv
// self-checking bench for the event, status and mask block
`timescale 1ns/100ps
`define CHK(g, e) \
  begin \
    check_count = check_count + 1; \
    if ((g) !== (e)) begin \
      n_fail = n_fail + 1; \
      $display("wrong value at %0t: got %h expected %h", $time, g, e); \
    end \
  end
module regulator_event_status_mask_tb_top;
  reg        clk_in;
  reg        reset_in;
  reg        ce;
  reg  [3:0] en;
  reg  [3:0] pg;
  reg  [3:0] cl;
  reg  [3:0] above;
  reg  [3:0] top;
  wire [7:0] addr;
  wire [7:0] wdata;
  wire [7:0] rdata;
  wire       wr;
  wire       rd;
  wire       sum_a;
  wire       sum_b;
  wire       irq_n;
  reg  [7:0] flg [0:1];
  reg  [7:0] msk [0:1];
  reg  [7:0] got;
  reg  [7:0] a;
  reg  [7:0] r;
  reg [31:0] rr;
  integer    seed;
  integer    n_fail;
  integer    check_count;
  integer    cyc = 0;
  integer    k;

  // short wait cut to 20 cycles so the slow-start case stays brief
  resm_top #(.SHORT_WAIT_CYCLES(16'h0014)) dut_u (.clk_in(clk_in), .reset_in(reset_in), .ce_in(ce),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_enabled_in(en),
    .reg_pgood_in(pg), .reg_curlimit_in(cl), .reg_above_short_level_in(above), .ext_clock_invalid_in(top[3]),
    .overtemp_shutdown_in(top[2]), .overtemp_warning_in(top[1]), .input_overvoltage_in(top[0]),
    .reg_rdata_out(rdata), .global_event_mask_one_out(), .global_event_mask_two_out(),
    .pair_a_summary_flag_out(sum_a), .pair_b_summary_flag_out(sum_b), .irq_out_n(irq_n));
  resm_host_model host_u (.clk_in(clk_in), .reg_rdata_in(rdata), .reg_addr_out(addr), .reg_wdata_out(wdata),
    .reg_wr_out(wr), .reg_rd_out(rd));

  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc = cyc + 1;
    if (cyc == 6000) begin
      n_fail = n_fail + 1;
      close_out;
    end
  end

  task close_out;
    begin
      $display("comparisons %0d, mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  // events are rising edges, so the model compares against the old levels
  task drive(input [3:0] e, input [3:0] p, input [3:0] c, input [3:0] t);
    integer i;
    begin
      @(negedge clk_in);
      for (i = 0; i < 4; i = i + 1) begin
        if (p[i] && !pg[i]) flg[i/2][2+4*(i%2)] = 1'b1;
        if (c[i] && !cl[i]) flg[i/2][4*(i%2)] = 1'b1;
      end
      en = e;
      pg = p;
      cl = c;
      top = t;
      repeat (4) @(negedge clk_in);
    end
  endtask
  task check_all;
    integer p;
    begin
      for (p = 0; p < 2; p = p + 1) begin
        host_u.rd_reg(8'h1c + p[7:0], got);
        `CHK(got, flg[p])
        host_u.rd_reg(8'h1f + p[7:0], got);
        `CHK(got, {en[2*p+1], pg[2*p+1], 1'b0, cl[2*p+1], en[2*p], pg[2*p], 1'b0, cl[2*p]})
      end
      host_u.rd_reg(8'h1e, got);
      `CHK(got, {3'b000, top, 1'b0})
      `CHK({sum_a, sum_b}, {flg[0] != 8'h00, flg[1] != 8'h00})
      `CHK(irq_n, ~|(((flg[0] & ~msk[0]) | (flg[1] & ~msk[1])) & 8'h77))
    end
  endtask

  initial begin
    seed = 63536;
    n_fail = 0;
    check_count = 0;
    reset_in = 1'b1;
    ce = 1'b1;
    {en, pg, cl, top} = 16'h0000;
    above = 4'hf;
    {flg[0], flg[1], msk[0], msk[1]} = 32'h0000_0000;
    repeat (3) @(posedge clk_in);
    @(negedge clk_in);
    reset_in = 1'b0;
    // a write while the enable is low must not land; the reset reads below show it
    ce = 1'b0;
    host_u.wr_reg(8'h21, 8'h00);
    ce = 1'b1;
    // reset values, then random writes; read-only and unmapped places keep zero
    for (k = 0; k < 20; k = k + 1) begin
      a = (k % 10 == 9) ? 8'h30 : 8'h1c + k[7:0] % 10;
      r = $random(seed);
      if (k > 9) host_u.wr_reg(a, r);
      if (k == 17 || k == 18) msk[k-17] = r & 8'hdd;
      host_u.rd_reg(a, got);
      `CHK(got, k == 15 || k == 16 ? r : k == 17 || k == 18 ? msk[k - 17] : k == 5 ? 8'h80 : 8'h00)
    end
    for (k = 0; k < 16; k = k + 1) begin
      r = $random(seed);
      host_u.wr_reg(8'h23 + k[0], r);
      msk[k % 2] = r & 8'hdd;
      rr = $random(seed);
      drive(rr[3:0], rr[7:4], rr[11:8], rr[15:12]);
      check_all;
      host_u.wr_reg(8'h1c + k[0], rr[23:16]);
      flg[k % 2] = flg[k % 2] & ~(rr[23:16] & 8'h77);
      check_all;
    end
    // shorts stay visible on the interrupt even with both pair masks set
    drive(4'h0, 4'h0, 4'h0, 4'h0);
    host_u.wr_reg(8'h1c, 8'hff);
    host_u.wr_reg(8'h1d, 8'hff);
    host_u.wr_reg(8'h23, 8'hff);
    host_u.wr_reg(8'h24, 8'hff);
    {flg[0], flg[1]} = 16'h0000;
    {msk[0], msk[1]} = 16'hdddd;
    above = 4'h7;
    drive(4'h9, 4'h0, 4'h0, 4'h0);
    repeat (30) @(negedge clk_in);
    flg[1][5] = 1'b1;
    above = 4'h6;
    repeat (4) @(negedge clk_in);
    flg[0][1] = 1'b1;
    check_all;
    close_out;
  end
endmodule

// >>> dv/resm_event_properties.sv
// port-level assertions for the event, status and mask block
`timescale 1ns/100ps
module resm_event_properties (
  input wire       clk_in,
  input wire       reset_in,
  input wire       ce_in,
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire       reg_wr_in,
  input wire       reg_rd_in,
  input wire [3:0] reg_enabled_in,
  input wire [3:0] reg_pgood_in,
  input wire [3:0] reg_curlimit_in,
  input wire       ext_clock_invalid_in,
  input wire       overtemp_shutdown_in,
  input wire       overtemp_warning_in,
  input wire       input_overvoltage_in,
  input wire [7:0] reg_rdata_out,
  input wire [7:0] global_event_mask_one_out,
  input wire [7:0] global_event_mask_two_out,
  input wire       pair_a_summary_flag_out,
  input wire       pair_b_summary_flag_out,
  input wire       irq_out_n
);
  // ----------------------------------------
  // properties on the rising edge
  // ----------------------------------------
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  rst_quiet_a:
  assert property (disable iff (!ce_in) reset_in |=> irq_out_n && !pair_a_summary_flag_out && !pair_b_summary_flag_out)
    else $error("outputs not quiet after reset");
  pgood_rise_a:
  assert property (ce_in && $rose(reg_pgood_in[0]) |-> ##[2:3] pair_a_summary_flag_out)
    else $error("power-good rise left no pending flag");
  curlim_rise_a:
  assert property (ce_in && $rose(reg_curlimit_in[3]) |-> ##[2:3] pair_b_summary_flag_out)
    else $error("current-limit rise left no pending flag");
  flag_hold_a:
  assert property (ce_in && pair_a_summary_flag_out && !$past(reset_in) && !$past(reg_wr_in && reg_addr_in == 8'h1c)
    |=> pair_a_summary_flag_out) else $error("pending flag dropped without a clear");
  top_status_a:
  assert property (ce_in && reg_rd_in && reg_addr_in == 8'h1e |=> reg_rdata_out == $past({3'b000,
    ext_clock_invalid_in, overtemp_shutdown_in, overtemp_warning_in, input_overvoltage_in, 1'b0}))
    else $error("global status read wrong");
  pair_status_a:
  assert property (ce_in && reg_rd_in && reg_addr_in == 8'h1f |=> reg_rdata_out == $past({reg_enabled_in[1],
    reg_pgood_in[1], 1'b0, reg_curlimit_in[1], reg_enabled_in[0], reg_pgood_in[0], 1'b0, reg_curlimit_in[0]}))
    else $error("pair status read wrong");
  mask_one_a:
  assert property (ce_in && reg_wr_in && reg_addr_in == 8'h21 |=> global_event_mask_one_out == $past(reg_wdata_in))
    else $error("first global mask not written");
  mask_two_a:
  assert property (ce_in && reg_wr_in && reg_addr_in == 8'h22 |=> global_event_mask_two_out == $past(reg_wdata_in))
    else $error("second global mask not written");
  irq_cause_a:
  assert property (!irq_out_n |-> pair_a_summary_flag_out || pair_b_summary_flag_out)
    else $error("interrupt low with no pending flag");
endmodule

bind resm_top resm_event_properties chk_u (.clk_in(clk_in), .reset_in(reset_in), .ce_in(ce_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_enabled_in(reg_enabled_in), .reg_pgood_in(reg_pgood_in), .reg_curlimit_in(reg_curlimit_in),
  .ext_clock_invalid_in(ext_clock_invalid_in), .overtemp_shutdown_in(overtemp_shutdown_in),
  .overtemp_warning_in(overtemp_warning_in), .input_overvoltage_in(input_overvoltage_in),
  .reg_rdata_out(reg_rdata_out), .global_event_mask_one_out(global_event_mask_one_out),
  .global_event_mask_two_out(global_event_mask_two_out), .pair_a_summary_flag_out(pair_a_summary_flag_out),
  .pair_b_summary_flag_out(pair_b_summary_flag_out), .irq_out_n(irq_out_n));

// >>> dv/resm_host_model.sv
// host side of the register port, strobes launched at falling edges
`timescale 1ns/100ps
module resm_host_model (
  input  wire       clk_in,
  input  wire [7:0] reg_rdata_in,
  output reg  [7:0] reg_addr_out,
  output reg  [7:0] reg_wdata_out,
  output reg        reg_wr_out,
  output reg        reg_rd_out
);
  initial begin
    reg_addr_out = 8'h00;
    reg_wdata_out = 8'h00;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
  end
  task wr_reg(input [7:0] a, input [7:0] d);
    begin
      @(negedge clk_in);
      reg_addr_out = a;
      reg_wdata_out = d;
      reg_wr_out = 1'b1;
      @(negedge clk_in);
      reg_wr_out = 1'b0;
      // stale data must not look valid after the strobe
      reg_wdata_out = ~d;
    end
  endtask
  task rd_reg(input [7:0] a, output [7:0] d);
    begin
      @(negedge clk_in);
      reg_addr_out = a;
      reg_rd_out = 1'b1;
      @(negedge clk_in);
      reg_rd_out = 1'b0;
      d = reg_rdata_in;
    end
  endtask
endmodule

// >>> verilog/resm_defs.vh
// register map, field positions and timing constants of the event/status/mask block
`ifndef RESM_DEFS_VH
`define RESM_DEFS_VH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define RESM_ADDR_PAIR_A_FLAGS   8'h1c
`define RESM_ADDR_PAIR_B_FLAGS   8'h1d
`define RESM_ADDR_GLOBAL_STATUS  8'h1e
`define RESM_ADDR_PAIR_A_STATUS  8'h1f
`define RESM_ADDR_PAIR_B_STATUS  8'h20
`define RESM_ADDR_GLOBAL_MASK1   8'h21
`define RESM_ADDR_GLOBAL_MASK2   8'h22
`define RESM_ADDR_PAIR_A_MASK    8'h23
`define RESM_ADDR_PAIR_B_MASK    8'h24

// ----------------------------------------------------------------------------
// field positions inside a pair register (upper regulator; lower one at -4) and the global status register
// ----------------------------------------------------------------------------
`define RESM_BIT_PGOOD           6
`define RESM_BIT_SHORT           5
`define RESM_BIT_CURLIMIT        4
`define RESM_BIT_ENABLED         7
`define RESM_UPPER_OFS           4
`define RESM_BIT_EXT_CLK_BAD     4
`define RESM_BIT_OVERTEMP_SD     3
`define RESM_BIT_OVERTEMP_WARN   2
`define RESM_BIT_INPUT_OVP       1

// ----------------------------------------------------------------------------
// writable bits and reset values
// ----------------------------------------------------------------------------
`define RESM_FLAGS_W1C_BITS      8'h77
`define RESM_PAIR_MASK_WR_BITS   8'hdd
`define RESM_GLOBAL_MASK_WR_BITS 8'hff
`define RESM_FLAGS_RESET         8'h00
`define RESM_MASK1_RESET         8'h80
`define RESM_MASK2_RESET         8'h00
`define RESM_PAIR_MASK_RESET     8'h00
`define RESM_ZERO_BYTE           8'h00

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
// 1 ms of the 40 MHz clock, kept at timer width
`define RESM_SHORT_WAIT_CYCLES   16'h9c40
`define RESM_TIMER_W             16

`endif

// >>> verilog/resm_regulator_monitor.v
// per-regulator event detection: power-good rise, short circuit, current-limit rise
`timescale 1ns/100ps
`include "resm_defs.vh"

module resm_regulator_monitor #(
  parameter [`RESM_TIMER_W-1:0] SHORT_WAIT_CYCLES = `RESM_SHORT_WAIT_CYCLES
) (
  input  wire clk_in,
  input  wire reset_in,
  input  wire ce_in,
  input  wire enabled_in,
  input  wire pgood_in,
  input  wire curlimit_in,
  input  wire above_short_level_in,
  output reg  pgood_event_out,
  output reg  short_event_out,
  output reg  curlimit_event_out
);

  // --------------------------------------------------------------------------
  // short-circuit sequencer
  // --------------------------------------------------------------------------
  localparam [1:0] ST_OFF      = 2'b00;
  localparam [1:0] ST_STARTING = 2'b01;
  localparam [1:0] ST_RUNNING  = 2'b10;
  localparam [1:0] ST_FAULTED  = 2'b11;

  reg [1:0]               state;
  reg [1:0]               next_state;
  reg [`RESM_TIMER_W-1:0] timer;
  reg [`RESM_TIMER_W-1:0] next_timer;
  reg                     next_short;
  reg                     pgood_prev;
  reg                     curlimit_prev;

  always @* begin
    next_state = state;
    next_timer = timer;
    next_short = 1'b0;
    if (!enabled_in) begin
      next_state = ST_OFF;
      next_timer = {`RESM_TIMER_W{1'b0}};
    end else begin
      case (state)
        ST_OFF: begin
          next_state = ST_STARTING;
          next_timer = {`RESM_TIMER_W{1'b0}};
        end
        ST_STARTING: begin
          if (above_short_level_in) begin
            next_state = ST_RUNNING;
          end else if (timer >= SHORT_WAIT_CYCLES - 1'b1) begin
            next_short = 1'b1;
            next_state = ST_FAULTED;
          end else begin
            next_timer = timer + 1'b1;
          end
        end
        ST_RUNNING: begin
          if (!above_short_level_in) begin
            next_short = 1'b1;
            next_state = ST_FAULTED;
          end
        end
        // one event per enable; the state stays ST_FAULTED until the enable drops
        ST_FAULTED: next_state = ST_FAULTED;
        default:    next_state = ST_OFF;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // state and edge detection
  // --------------------------------------------------------------------------
  always @(posedge clk_in) begin
    if (reset_in) begin
      state              <= ST_OFF;
      timer              <= {`RESM_TIMER_W{1'b0}};
      pgood_prev         <= 1'b0;
      curlimit_prev      <= 1'b0;
      pgood_event_out    <= 1'b0;
      short_event_out    <= 1'b0;
      curlimit_event_out <= 1'b0;
    end else if (ce_in) begin
      state              <= next_state;
      timer              <= next_timer;
      pgood_prev         <= pgood_in;
      curlimit_prev      <= curlimit_in;
      pgood_event_out    <= pgood_in & ~pgood_prev;
      short_event_out    <= next_short;
      curlimit_event_out <= curlimit_in & ~curlimit_prev;
    end
  end

endmodule

// >>> verilog/resm_top.v
// event flags, live status, masks and interrupt output of the four-regulator controller
//
// Operation
// - power-good reach latches flag, bit 6/2
// - short or slow start latches short flag
// - current-limit onset latches flag, bit 4/0
// - flags reset zero, cleared by writing one
// - global bit 4 shows external clock invalid
// - global bit 3 shows thermal shutdown
// - global bit 2 shows thermal warning
// - global bit 1 shows input overvoltage
// - pair bit 7/3 shows regulator enabled
// - pair bit 6/2 shows raw power-good
// - pair bit 4/0 shows raw current limit
// - mask zero allows interrupt, one suppresses; only pair masks gate the interrupt, global masks only drive their outputs
// - masks never alter live status bits
// - global mask one bit 4: clock event
// - global mask one bit 2: thermal warning
// - global mask one bit 0: load-current ready
// - global mask two bit 0: register reset
// - pair mask bit 6/2: power-good event
// - pair mask bit 4/0: current-limit event
// - pair summary set while pair flags nonzero
`timescale 1ns/100ps
`include "resm_defs.vh"

module resm_top #(
  parameter [`RESM_TIMER_W-1:0] SHORT_WAIT_CYCLES = `RESM_SHORT_WAIT_CYCLES
) (
  input  wire       clk_in,
  input  wire       reset_in,
  input  wire       ce_in,
  input  wire [7:0] reg_addr_in,
  input  wire [7:0] reg_wdata_in,
  input  wire       reg_wr_in,
  input  wire       reg_rd_in,
  input  wire [3:0] reg_enabled_in,
  input  wire [3:0] reg_pgood_in,
  input  wire [3:0] reg_curlimit_in,
  input  wire [3:0] reg_above_short_level_in,
  input  wire       ext_clock_invalid_in,
  input  wire       overtemp_shutdown_in,
  input  wire       overtemp_warning_in,
  input  wire       input_overvoltage_in,
  output reg  [7:0] reg_rdata_out,
  output reg  [7:0] global_event_mask_one_out,
  output reg  [7:0] global_event_mask_two_out,
  output reg        pair_a_summary_flag_out,
  output reg        pair_b_summary_flag_out,
  output reg        irq_out_n
);

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  // set wins over clear so an event in the clearing cycle is kept
  function [7:0] resm_w1c;
    input [7:0] flags;
    input [7:0] set_bits;
    input       clear_hit;
    input [7:0] clear_bits;
    begin
      if (clear_hit) begin
        resm_w1c = (flags & ~(clear_bits & `RESM_FLAGS_W1C_BITS)) | set_bits;
      end else begin
        resm_w1c = flags | set_bits;
      end
    end
  endfunction

  function [3:0] resm_status_nibble;
    input enabled;
    input pgood;
    input curlimit;
    begin
      resm_status_nibble = {enabled, pgood, 1'b0, curlimit};
    end
  endfunction

  function [7:0] resm_masked_write;
    input [7:0] old_value;
    input [7:0] new_value;
    input [7:0] wr_bits;
    begin
      resm_masked_write = (old_value & ~wr_bits) | (new_value & wr_bits);
    end
  endfunction

  // --------------------------------------------------------------------------
  // per-regulator monitors
  // --------------------------------------------------------------------------
  wire [3:0] pgood_event;
  wire [3:0] short_event;
  wire [3:0] curlimit_event;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gen_monitor
      resm_regulator_monitor #(
        .SHORT_WAIT_CYCLES (SHORT_WAIT_CYCLES)
      ) u_monitor (
        .clk_in               (clk_in),
        .reset_in             (reset_in),
        .ce_in                (ce_in),
        .enabled_in           (reg_enabled_in[g]),
        .pgood_in             (reg_pgood_in[g]),
        .curlimit_in          (reg_curlimit_in[g]),
        .above_short_level_in (reg_above_short_level_in[g]),
        .pgood_event_out      (pgood_event[g]),
        .short_event_out      (short_event[g]),
        .curlimit_event_out   (curlimit_event[g])
      );
    end
  endgenerate

  // --------------------------------------------------------------------------
  // event flag registers
  // --------------------------------------------------------------------------
  reg  [7:0] pair_a_event_flags;
  reg  [7:0] pair_b_event_flags;
  reg  [7:0] pair_a_event_mask;
  reg  [7:0] pair_b_event_mask;
  wire [7:0] set_a;
  wire [7:0] set_b;
  wire [7:0] next_flags_a;
  wire [7:0] next_flags_b;

  // lower regulator in the low nibble, upper one shifted up
  assign set_a = {1'b0, pgood_event[1], short_event[1], curlimit_event[1],
                  1'b0, pgood_event[0], short_event[0], curlimit_event[0]};
  assign set_b = {1'b0, pgood_event[3], short_event[3], curlimit_event[3],
                  1'b0, pgood_event[2], short_event[2], curlimit_event[2]};

  assign next_flags_a = resm_w1c(pair_a_event_flags, set_a,
                                 reg_wr_in && reg_addr_in == `RESM_ADDR_PAIR_A_FLAGS,
                                 reg_wdata_in);
  assign next_flags_b = resm_w1c(pair_b_event_flags, set_b,
                                 reg_wr_in && reg_addr_in == `RESM_ADDR_PAIR_B_FLAGS,
                                 reg_wdata_in);

  // --------------------------------------------------------------------------
  // interrupt gating
  // --------------------------------------------------------------------------
  // short flags have no mask bit; mask bits 5 and 1 always read zero
  wire pending;
  assign pending = |(pair_a_event_flags & ~pair_a_event_mask) |
                   |(pair_b_event_flags & ~pair_b_event_mask);

  // --------------------------------------------------------------------------
  // live status views
  // --------------------------------------------------------------------------
  // raw inputs only; masks are never folded in
  wire [7:0] global_live_status;
  wire [7:0] pair_a_live_status;
  wire [7:0] pair_b_live_status;

  assign global_live_status = {3'b000,
                               ext_clock_invalid_in,
                               overtemp_shutdown_in,
                               overtemp_warning_in,
                               input_overvoltage_in,
                               1'b0};
  assign pair_a_live_status = {resm_status_nibble(reg_enabled_in[1], reg_pgood_in[1], reg_curlimit_in[1]),
                               resm_status_nibble(reg_enabled_in[0], reg_pgood_in[0],
                                                  reg_curlimit_in[0])};
  assign pair_b_live_status = {resm_status_nibble(reg_enabled_in[3], reg_pgood_in[3], reg_curlimit_in[3]),
                               resm_status_nibble(reg_enabled_in[2], reg_pgood_in[2],
                                                  reg_curlimit_in[2])};

  // --------------------------------------------------------------------------
  // read decode
  // --------------------------------------------------------------------------
  reg [7:0] read_value;

  always @* begin
    case (reg_addr_in)
      `RESM_ADDR_PAIR_A_FLAGS:  read_value = pair_a_event_flags;
      `RESM_ADDR_PAIR_B_FLAGS:  read_value = pair_b_event_flags;
      `RESM_ADDR_GLOBAL_STATUS: read_value = global_live_status;
      `RESM_ADDR_PAIR_A_STATUS: read_value = pair_a_live_status;
      `RESM_ADDR_PAIR_B_STATUS: read_value = pair_b_live_status;
      `RESM_ADDR_GLOBAL_MASK1:  read_value = global_event_mask_one_out;
      `RESM_ADDR_GLOBAL_MASK2:  read_value = global_event_mask_two_out;
      `RESM_ADDR_PAIR_A_MASK:   read_value = pair_a_event_mask;
      `RESM_ADDR_PAIR_B_MASK:   read_value = pair_b_event_mask;
      default:                  read_value = `RESM_ZERO_BYTE;
    endcase
  end

  // --------------------------------------------------------------------------
  // register state
  // --------------------------------------------------------------------------
  always @(posedge clk_in) begin
    if (reset_in) begin
      pair_a_event_flags        <= `RESM_FLAGS_RESET;
      pair_b_event_flags        <= `RESM_FLAGS_RESET;
      pair_a_event_mask         <= `RESM_PAIR_MASK_RESET;
      pair_b_event_mask         <= `RESM_PAIR_MASK_RESET;
      global_event_mask_one_out <= `RESM_MASK1_RESET;
      global_event_mask_two_out <= `RESM_MASK2_RESET;
      reg_rdata_out             <= `RESM_ZERO_BYTE;
      pair_a_summary_flag_out   <= 1'b0;
      pair_b_summary_flag_out   <= 1'b0;
      irq_out_n                 <= 1'b1;
    end else if (ce_in) begin
      pair_a_event_flags <= next_flags_a;
      pair_b_event_flags <= next_flags_b;
      if (reg_wr_in) begin
        case (reg_addr_in)
          `RESM_ADDR_GLOBAL_MASK1: global_event_mask_one_out <= resm_masked_write(
            global_event_mask_one_out, reg_wdata_in, `RESM_GLOBAL_MASK_WR_BITS);
          `RESM_ADDR_GLOBAL_MASK2: global_event_mask_two_out <= resm_masked_write(
            global_event_mask_two_out, reg_wdata_in, `RESM_GLOBAL_MASK_WR_BITS);
          `RESM_ADDR_PAIR_A_MASK: pair_a_event_mask <= resm_masked_write(
            pair_a_event_mask, reg_wdata_in, `RESM_PAIR_MASK_WR_BITS);
          `RESM_ADDR_PAIR_B_MASK: pair_b_event_mask <= resm_masked_write(
            pair_b_event_mask, reg_wdata_in, `RESM_PAIR_MASK_WR_BITS);
          default: begin
          end
        endcase
      end
      if (reg_rd_in) begin
        reg_rdata_out <= read_value;
      end
      // outputs follow the flag registers one cycle later
      pair_a_summary_flag_out <= |pair_a_event_flags;
      pair_b_summary_flag_out <= |pair_b_event_flags;
      irq_out_n               <= ~pending;
    end
  end

endmodule
